// [hdl/adc_cfg_pkg.sv]
// Purpose: Shared constants for the converter configuration bank
// Assumes: 8-bit registers, byte-wide register port
// Notes: Range-select register offset is arbitrary
package adc_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 14;
  localparam logic [7:0] OFF_POWER = 8'h43;
  localparam logic [7:0] OFF_PERF = 8'h4A;
  localparam logic [7:0] OFF_PEDESTAL = 8'hBF;
  localparam logic [7:0] OFF_LOOP = 8'hCF;
  localparam logic [7:0] OFF_RANGE = 8'hD0;
  localparam logic [7:0] RST_REG = 8'h00;
  // Writable bit masks; reserved bits store zero
  localparam logic [7:0] MASK_POWER = 8'h53;
  localparam logic [7:0] MASK_PERF = 8'h01;
  localparam logic [7:0] MASK_PEDESTAL = 8'hFC;
  localparam logic [7:0] MASK_LOOP = 8'hBC;
  localparam logic [7:0] MASK_RANGE = 8'h30;
  localparam int BIT_TOTAL_PDN = 6;
  localparam int BIT_OBUF_PDN = 4;
  localparam int BIT_SWING_LO = 0;
  localparam int BIT_HIFREQ = 0;
  localparam int BIT_PED_LO = 2;
  localparam int PED_W = 6;
  localparam int BIT_HOLD = 7;
  localparam int BIT_PERIOD_LO = 2;
  localparam int PERIOD_W = 4;
  localparam int BIT_RANGE_LO = 4;
  localparam logic [1:0] SWING_ON = 2'h3;
  localparam logic [1:0] LOW_SPEED_ON = 2'h3;
  // Loop length is 2^(BASE_SHIFT + code): code 0 gives 1M cycles
  localparam int BASE_SHIFT = 20;
  localparam logic [3:0] PERIOD_MAX = 4'hB;
endpackage

// [hdl/adc_config_offset_power_regs.sv]
// Purpose: Configuration registers for power, swing, performance, offset
// Assumes: Register port on REF_CLK_I, samples one per clock
// Notes: Read data valid the cycle after the read strobe
//
// Overview of operation
// - Output-buffer power-down tristates data and clock output pins.
// - Swing field 11 enables swing control, 00 disables it.
// - Performance bit zero default, one for high input frequencies.
// - Performance register resets to zero.
// - Correction converges output to mid-code plus pedestal.
// - Pedestal is six-bit two's complement, -32 to +31 LSB.
// - Hold bit freezes estimate, last value applied each cycle.
// - Hold clear keeps estimate updating continuously.
// - Loop period code N gives 2^(20+N) cycles, up to 2G.
// - Range field 11 enables low-speed mode, else disabled.
// - Lower-rate variants run low-speed from reset, field not written.
// - Correction works only when digital path enable is one.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module adc_config_offset_power_regs #(
  parameter bit LOW_RATE_VARIANT = 1'b0,
  parameter int SAMPLE_W = adc_cfg_pkg::SAMPLE_W
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Register port
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [adc_cfg_pkg::DATA_W-1:0] RDATA_O,
  // Controls from elsewhere
  input wire logic DIGITAL_PATH_ENABLE_I,
  input wire logic CORRECTION_ENABLE_I,
  // Sample path
  input wire logic [SAMPLE_W-1:0] SAMPLE_I,
  output logic [SAMPLE_W-1:0] SAMPLE_O,
  output logic [SAMPLE_W-1:0] OUT_DATA_O,
  output logic OUT_DATA_OE_O,
  output logic OUT_CLK_O,
  output logic OUT_CLK_OE_O,
  // Analog controls and correction status
  output logic TOTAL_POWER_DOWN_O,
  output logic OUTPUT_BUFFER_POWER_DOWN_O,
  output logic SWING_CONTROL_ENABLE_O,
  output logic HIGH_FREQ_PERFORMANCE_O,
  output logic LOW_SPEED_MODE_O,
  output logic CORRECTION_ACTIVE_O,
  output logic HOLD_CORRECTION_ESTIMATE_O
);
  if (SAMPLE_W < 8 || SAMPLE_W > 16) begin : g_bad_sample_w
    $error("adc_config_offset_power_regs: SAMPLE_W out of range");
  end

  typedef struct packed {
    logic [7:0] power;
    logic [7:0] perf;
    logic [7:0] pedestal;
    logic [7:0] loop_ctl;
    logic [7:0] range_sel;
    logic [7:0] rdata;
    logic [SAMPLE_W-1:0] out_data;
    logic out_clk;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic [7:0] wmasked;
  logic [7:0] rd_mux;
  logic corr_active;
  logic hold;
  logic [3:0] period_code;
  logic [5:0] shift;
  logic low_speed;
  logic [SAMPLE_W-1:0] corrected;

  assign wmasked = WDATA_I;

  always_comb begin
    case (ADDR_I)
      adc_cfg_pkg::OFF_POWER: rd_mux = cur_ff.power;
      adc_cfg_pkg::OFF_PERF: rd_mux = cur_ff.perf;
      adc_cfg_pkg::OFF_PEDESTAL: rd_mux = cur_ff.pedestal;
      adc_cfg_pkg::OFF_LOOP: rd_mux = cur_ff.loop_ctl;
      adc_cfg_pkg::OFF_RANGE: rd_mux = cur_ff.range_sel;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    nxt_cur = cur_ff;
    if (WR_I) begin
      case (ADDR_I)
        adc_cfg_pkg::OFF_POWER: begin
          nxt_cur.power = wmasked & adc_cfg_pkg::MASK_POWER;
        end
        adc_cfg_pkg::OFF_PERF: begin
          nxt_cur.perf = wmasked & adc_cfg_pkg::MASK_PERF;
        end
        adc_cfg_pkg::OFF_PEDESTAL: begin
          nxt_cur.pedestal = wmasked & adc_cfg_pkg::MASK_PEDESTAL;
        end
        adc_cfg_pkg::OFF_LOOP: begin
          nxt_cur.loop_ctl = wmasked & adc_cfg_pkg::MASK_LOOP;
        end
        adc_cfg_pkg::OFF_RANGE: begin
          if (!LOW_RATE_VARIANT) begin
            nxt_cur.range_sel = wmasked & adc_cfg_pkg::MASK_RANGE;
          end
        end
        default: begin
          nxt_cur.power = cur_ff.power;
        end
      endcase
    end
    nxt_cur.rdata = RD_I ? rd_mux : 8'h00;
    nxt_cur.out_data = corrected;
    nxt_cur.out_clk = ~cur_ff.out_clk;
    if (cur_ff.power[adc_cfg_pkg::BIT_TOTAL_PDN]) begin
      nxt_cur.out_data = '0;
      nxt_cur.out_clk = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign corr_active = CORRECTION_ENABLE_I && DIGITAL_PATH_ENABLE_I
    && !cur_ff.power[adc_cfg_pkg::BIT_TOTAL_PDN];
  assign hold = cur_ff.loop_ctl[adc_cfg_pkg::BIT_HOLD];
  assign period_code = cur_ff.loop_ctl[adc_cfg_pkg::BIT_PERIOD_LO +:
    adc_cfg_pkg::PERIOD_W];

  // loop length, codes above max clamp
  always_comb begin
    if (period_code > adc_cfg_pkg::PERIOD_MAX) begin
      shift = 6'(adc_cfg_pkg::BASE_SHIFT) + 6'(adc_cfg_pkg::PERIOD_MAX);
    end else begin
      shift = 6'(adc_cfg_pkg::BASE_SHIFT) + {2'h0, period_code};
    end
  end

  offset_estimator #(
    .SAMPLE_W(SAMPLE_W),
    .ACC_W(SAMPLE_W + 40)
  ) u_est (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .active_i(corr_active),
    .hold_i(hold),
    .shift_i(shift),
    .pedestal_i(cur_ff.pedestal[adc_cfg_pkg::BIT_PED_LO +:
      adc_cfg_pkg::PED_W]),
    .sample_i(SAMPLE_I),
    .sample_o(corrected)
  );

  assign low_speed = LOW_RATE_VARIANT ? 1'b1 :
    (cur_ff.range_sel[adc_cfg_pkg::BIT_RANGE_LO +: 2] ==
     adc_cfg_pkg::LOW_SPEED_ON);

  assign RDATA_O = cur_ff.rdata;
  assign SAMPLE_O = corrected;
  assign OUT_DATA_O = cur_ff.out_data;
  assign OUT_CLK_O = cur_ff.out_clk;
  assign OUT_DATA_OE_O = !cur_ff.power[adc_cfg_pkg::BIT_OBUF_PDN]
    && !cur_ff.power[adc_cfg_pkg::BIT_TOTAL_PDN];
  assign OUT_CLK_OE_O = OUT_DATA_OE_O;
  assign TOTAL_POWER_DOWN_O = cur_ff.power[adc_cfg_pkg::BIT_TOTAL_PDN];
  assign OUTPUT_BUFFER_POWER_DOWN_O =
    cur_ff.power[adc_cfg_pkg::BIT_OBUF_PDN];
  assign SWING_CONTROL_ENABLE_O =
    (cur_ff.power[adc_cfg_pkg::BIT_SWING_LO +: 2] == adc_cfg_pkg::SWING_ON);
  assign HIGH_FREQ_PERFORMANCE_O = cur_ff.perf[adc_cfg_pkg::BIT_HIFREQ];
  assign LOW_SPEED_MODE_O = low_speed;
  assign CORRECTION_ACTIVE_O = corr_active;
  assign HOLD_CORRECTION_ESTIMATE_O = hold && corr_active;
endmodule

// [hdl/offset_estimator.sv]
// Purpose: First-order offset estimator and sample correction
// Assumes: One sample per clock, two's-complement samples
// Notes: Averaging length is 2^shift cycles
`timescale 1ns/100ps
module offset_estimator #(
  parameter int SAMPLE_W = 14,
  parameter int ACC_W = 48
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic active_i,
  input wire logic hold_i,
  input wire logic [5:0] shift_i,
  input wire logic signed [5:0] pedestal_i,
  // Samples
  input wire logic signed [SAMPLE_W-1:0] sample_i,
  output logic signed [SAMPLE_W-1:0] sample_o
);
  // Widths the shifter and accumulator cannot serve
  if (SAMPLE_W < 8 || ACC_W < SAMPLE_W + 32) begin : g_bad_width
    $error("offset_estimator: unsupported widths");
  end

  typedef struct packed {
    logic signed [ACC_W-1:0] acc;
    logic signed [SAMPLE_W-1:0] out;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic signed [ACC_W-1:0] est;
  logic signed [ACC_W-1:0] err;
  logic signed [ACC_W-1:0] corr;

  always_comb begin
    nxt_cur = cur_ff;
    est = cur_ff.acc >>> shift_i;
    corr = ACC_W'(sample_i) - est;
    // Error against mid-code plus pedestal
    err = corr - ACC_W'(pedestal_i);
    if (!active_i) begin
      nxt_cur.acc = '0;
      nxt_cur.out = sample_i;
    end else begin
      if (!hold_i) begin
        nxt_cur.acc = cur_ff.acc + err;
      end
      nxt_cur.out = corr[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sample_o = cur_ff.out;
endmodule

// [verif/adc_cfg_monitor.sv]
// Purpose: Port checks for the configuration bank
// Assumes: Default parameters, one clock
// Notes: Bound to the top module
`timescale 1ns/100ps
module adc_cfg_monitor (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  // Controls and outputs
  input wire logic DIGITAL_PATH_ENABLE_I,
  input wire logic CORRECTION_ENABLE_I,
  input wire logic OUT_DATA_OE_O,
  input wire logic OUT_CLK_OE_O,
  input wire logic TOTAL_POWER_DOWN_O,
  input wire logic OUTPUT_BUFFER_POWER_DOWN_O,
  input wire logic SWING_CONTROL_ENABLE_O,
  input wire logic HIGH_FREQ_PERFORMANCE_O,
  input wire logic LOW_SPEED_MODE_O,
  input wire logic CORRECTION_ACTIVE_O,
  input wire logic HOLD_CORRECTION_ESTIMATE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_obuf_tristate: assert property (
    OUTPUT_BUFFER_POWER_DOWN_O |-> !OUT_DATA_OE_O && !OUT_CLK_OE_O)
    else $error("buffer power-down left pins driven");
  a_total_tristate: assert property (
    TOTAL_POWER_DOWN_O |-> !OUT_DATA_OE_O && !OUT_CLK_OE_O)
    else $error("total power-down left pins driven");
  a_obuf_write: assert property (
    WR_I && ADDR_I == 8'h43 |=>
    OUTPUT_BUFFER_POWER_DOWN_O == $past(WDATA_I[4]))
    else $error("buffer power-down bit mismatch");
  a_total_write: assert property (
    WR_I && ADDR_I == 8'h43 |=> TOTAL_POWER_DOWN_O == $past(WDATA_I[6]))
    else $error("total power-down bit mismatch");
  a_swing_write: assert property (
    WR_I && ADDR_I == 8'h43 |=>
    SWING_CONTROL_ENABLE_O == ($past(WDATA_I[1:0]) == 2'h3))
    else $error("swing enable mismatch");
  a_perf_write: assert property (
    WR_I && ADDR_I == 8'h4A |=>
    HIGH_FREQ_PERFORMANCE_O == $past(WDATA_I[0]))
    else $error("performance bit mismatch");
  a_range_write: assert property (
    WR_I && ADDR_I == 8'hD0 |=>
    LOW_SPEED_MODE_O == ($past(WDATA_I[5:4]) == 2'h3))
    else $error("low-speed mode mismatch");
  a_hold_gate: assert property (
    HOLD_CORRECTION_ESTIMATE_O |-> CORRECTION_ACTIVE_O)
    else $error("hold while correction inactive");
  a_path_gate: assert property (
    CORRECTION_ACTIVE_O == (DIGITAL_PATH_ENABLE_I &&
    CORRECTION_ENABLE_I && !TOTAL_POWER_DOWN_O))
    else $error("correction active without enables");
  a_hold_write: assert property (
    WR_I && ADDR_I == 8'hCF |=>
    HOLD_CORRECTION_ESTIMATE_O == ($past(WDATA_I[7]) && CORRECTION_ACTIVE_O))
    else $error("hold bit mismatch");
  a_pins_driven: assert property (
    !OUTPUT_BUFFER_POWER_DOWN_O && !TOTAL_POWER_DOWN_O |->
    OUT_DATA_OE_O && OUT_CLK_OE_O)
    else $error("output pins not driven while powered");
endmodule
bind adc_config_offset_power_regs adc_cfg_monitor mon (.*);

// [verif/tb_adc_config_offset_power_regs.sv]
// Purpose: Directed bench for the configuration bank
// Assumes: Default parameters plus one lower-rate instance, 10 MHz clock
// Notes: Short loop runs check the first steps of the estimate
`timescale 1ns/100ps
module tb_adc_config_offset_power_regs;
  logic REF_CLK_I = 0, RSTN_I = 0, WR_I = 0, RD_I = 0;
  logic [7:0] ADDR_I = 0, WDATA_I = 0, RDATA_O;
  logic DIGITAL_PATH_ENABLE_I = 1, CORRECTION_ENABLE_I = 1;
  logic [13:0] SAMPLE_I = 14'h0123, SAMPLE_O, OUT_DATA_O;
  logic OUT_DATA_OE_O, OUT_CLK_O, OUT_CLK_OE_O, TOTAL_POWER_DOWN_O;
  logic OUTPUT_BUFFER_POWER_DOWN_O, SWING_CONTROL_ENABLE_O;
  logic HIGH_FREQ_PERFORMANCE_O, LOW_SPEED_MODE_O;
  logic CORRECTION_ACTIVE_O, HOLD_CORRECTION_ESTIMATE_O;
  int n_fail = 0;
  int checked = 0;
  logic low_rate_speed;
  adc_config_offset_power_regs dut (.*);
  // Lower-rate variant, register port left idle
  adc_config_offset_power_regs #(.LOW_RATE_VARIANT(1'b1)) dut_low (
    .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
    .ADDR_I(8'h00), .WDATA_I(8'h00), .WR_I(1'b0), .RD_I(1'b0),
    .RDATA_O(),
    .DIGITAL_PATH_ENABLE_I(1'b0), .CORRECTION_ENABLE_I(1'b0),
    .SAMPLE_I(14'h0000), .SAMPLE_O(), .OUT_DATA_O(),
    .OUT_DATA_OE_O(), .OUT_CLK_O(), .OUT_CLK_OE_O(),
    .TOTAL_POWER_DOWN_O(), .OUTPUT_BUFFER_POWER_DOWN_O(),
    .SWING_CONTROL_ENABLE_O(), .HIGH_FREQ_PERFORMANCE_O(),
    .LOW_SPEED_MODE_O(low_rate_speed),
    .CORRECTION_ACTIVE_O(), .HOLD_CORRECTION_ESTIMATE_O()
  );
  always #50 REF_CLK_I = ~REF_CLK_I;
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge REF_CLK_I);
    WR_I <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge REF_CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge REF_CLK_I);
    RD_I <= 1'b0;
    #1;
    chk(RDATA_O, exp);
  endtask
  task automatic t_reset;
    rd(8'h43, 8'h00);
    rd(8'h4A, 8'h00);
    rd(8'hBF, 8'h00);
    rd(8'hCF, 8'h00);
    rd(8'h55, 8'h00);
    chk(LOW_SPEED_MODE_O, 1'b0);
    chk(low_rate_speed, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_power;
    logic clk_seen;
    wr(8'h43, 8'h10);
    chk(OUTPUT_BUFFER_POWER_DOWN_O, 1'b1);
    chk(OUT_DATA_OE_O, 1'b0);
    chk(OUT_CLK_OE_O, 1'b0);
    wr(8'h43, 8'h40);
    chk(TOTAL_POWER_DOWN_O, 1'b1);
    chk(CORRECTION_ACTIVE_O, 1'b0);
    repeat (3) @(posedge REF_CLK_I);
    #1;
    chk(OUT_DATA_O, 14'h0);
    chk(OUT_CLK_O, 1'b0);
    wr(8'h43, 8'h53);
    rd(8'h43, 8'h53);
    chk(SWING_CONTROL_ENABLE_O, 1'b1);
    wr(8'h43, 8'h00);
    chk(SWING_CONTROL_ENABLE_O, 1'b0);
    chk(OUT_DATA_OE_O, 1'b1);
    clk_seen = OUT_CLK_O;
    @(posedge REF_CLK_I);
    #1;
    chk(OUT_CLK_O, !clk_seen);
    $display("power test done");
  endtask
  task automatic t_perf;
    wr(8'h4A, 8'h01);
    rd(8'h4A, 8'h01);
    chk(HIGH_FREQ_PERFORMANCE_O, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(8'hD0, {2'h0, i[1:0], 4'h0});
      chk(LOW_SPEED_MODE_O, i == 3);
    end
    $display("mode test done");
  endtask
  task automatic t_corr;
    wr(8'hCF, 8'hBC);
    rd(8'hCF, 8'hBC);
    chk(HOLD_CORRECTION_ESTIMATE_O, 1'b1);
    wr(8'hBF, 8'hFC);
    rd(8'hBF, 8'hFC);
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b0;
    repeat (3) @(posedge REF_CLK_I);
    #1;
    chk(CORRECTION_ACTIVE_O, 1'b0);
    chk(HOLD_CORRECTION_ESTIMATE_O, 1'b0);
    chk(SAMPLE_O, 14'h0123);
    chk(OUT_DATA_O, 14'h0123);
    $display("correction test done");
  endtask
  task automatic t_loop;
    // Inactive path clears the estimate between phases
    @(posedge REF_CLK_I);
    SAMPLE_I <= 14'h0000;
    wr(8'hCF, 8'h00);
    wr(8'hBF, 8'h80);
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b1;
    repeat (20) @(posedge REF_CLK_I);
    #1;
    chk(SAMPLE_O, 14'h0000);
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b0;
    wr(8'hBF, 8'h7C);
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b1;
    repeat (20) @(posedge REF_CLK_I);
    #1;
    chk(SAMPLE_O, 14'h0001);
    chk(OUT_DATA_O, 14'h0001);
    // Full-scale sample: estimate reaches 1 after 128 cycles
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b0;
    SAMPLE_I <= 14'h1FFF;
    wr(8'hBF, 8'h80);
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b1;
    repeat (20) @(posedge REF_CLK_I);
    #1;
    chk(SAMPLE_O, 14'h1FFF);
    repeat (180) @(posedge REF_CLK_I);
    #1;
    chk(SAMPLE_O, 14'h1FFE);
    // Unfrozen, the estimate would reach 2 within 60 cycles
    wr(8'hCF, 8'h80);
    repeat (200) @(posedge REF_CLK_I);
    #1;
    chk(HOLD_CORRECTION_ESTIMATE_O, 1'b1);
    chk(SAMPLE_O, 14'h1FFE);
    // Code 1 doubles the length: first step after 256 cycles
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b0;
    wr(8'hCF, 8'h04);
    @(posedge REF_CLK_I);
    DIGITAL_PATH_ENABLE_I <= 1'b1;
    repeat (200) @(posedge REF_CLK_I);
    #1;
    chk(SAMPLE_O, 14'h1FFF);
    repeat (100) @(posedge REF_CLK_I);
    #1;
    chk(SAMPLE_O, 14'h1FFE);
    $display("loop test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge REF_CLK_I);
    RSTN_I <= 1'b1;
    t_reset();
    t_power();
    t_perf();
    t_corr();
    t_loop();
    final_report();
  end
  initial begin
    #500000;
    n_fail++;
    final_report();
  end
endmodule
